// File: dv/video_scaler_vertical_output_control_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the vertical and output control block
module video_scaler_vertical_output_control_tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic scl = 1'b1;
	logic sda_m = 1'b1;
	logic sel = 1'b0;
	logic [7:0] luma = 8'h00;
	logic [7:0] chroma = 8'h00;
	logic line_reference = 1'b0;
	logic oef = 1'b0;
	logic free_run = 1'b0;
	logic slow = 1'b0;
	wire sda_w;
	wire vram_port_clock, oen, sda_o, sda_oe, line_qualifier, pixel_qualifier, flag, address_increment_strobe, oe_o, key;
	wire [31:0] video_ram_output_port, word;
	int fail_count = 0;
	int n_compared = 0;
	// open-drain data line with pull-up
	assign sda_w = sda_m && !(sda_oe && !sda_o);
	always #2.5 ref_clk_i = ~ref_clk_i;
	// device under test
	vsvoc_top dut (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.scl_i(scl),
		.sda_i(sda_w),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe),
		.address_select_pin_i(sel),
		.luma_input_i(luma),
		.chroma_input_i(chroma),
		.line_reference_i(line_reference),
		.field_sync_i(1'b0),
		.odd_even_flag_i(oef),
		.output_format_select_i(2'h0),
		.vram_port_clock_i(vram_port_clock),
		.port_output_enable_i(oen),
		.video_ram_output_port_o(video_ram_output_port),
		.line_qualifier_o(line_qualifier),
		.pixel_qualifier_o(pixel_qualifier),
		.transfer_request_flag_o(flag),
		.address_increment_strobe_o(address_increment_strobe),
		.odd_even_o(oe_o),
		.key_o(key)
	);
	// far-side controller
	vsvoc_vram_ctrl u_ram (
		.rst_i(rst_i),
		.free_run_i(free_run),
		.slow_i(slow),
		.transfer_request_flag_i(flag),
		.word_i(video_ram_output_port),
		.vram_port_clock_o(vram_port_clock),
		.port_output_enable_o(oen),
		.word_o(word)
	);
	// comparisons
	task automatic cmp1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask : cmp1
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : cmp32
	task automatic close_out;
		if (fail_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	task automatic ticks(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : ticks
	// one bus bit; long phases let the slave's synchroniser keep up
	task automatic bit_out(input logic b, output logic seen);
		sda_m = b;
		ticks(10);
		scl = 1'b1;
		ticks(5);
		seen = sda_w;
		ticks(5);
		scl = 1'b0;
	endtask : bit_out
	task automatic send_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_out(v[i], s);
		bit_out(1'b1, s);
		ack = !s;
	endtask : send_byte
	// start, address, subaddress, one data byte, stop
	task automatic reg_write(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d, input logic exp_ack);
		logic a;
		logic b;
		sda_m = 1'b0;
		ticks(10);
		scl = 1'b0;
		send_byte(dev, a);
		send_byte(sub, b);
		send_byte(d, b);
		sda_m = 1'b0;
		ticks(10);
		scl = 1'b1;
		ticks(10);
		sda_m = 1'b1;
		ticks(20);
		cmp1(a, exp_ack);
	endtask : reg_write
	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		reg_write(8'hB8, sub, d, 1'b1);
		ticks(8);
	endtask : wr
	// bounded wait for the request flag
	task automatic wait_flag(input logic v);
		int k;
		k = 0;
		while (flag !== v && k < 400) begin
			ticks(1);
			k++;
		end
		cmp1(flag, v);
		if (k == 400) close_out();
	endtask : wait_flag
	// main sequence
	initial begin
		ticks(8);
		rst_i = 1'b0;
		ticks(4);
		cmp1(key, 1'b0);
		cmp1(flag, 1'b0);
		reg_write(8'hBC, 8'h10, 8'h00, 1'b0);
		reg_write(8'hB8, 8'h10, 8'h00, 1'b1);
		sel = 1'b1;
		ticks(4);
		reg_write(8'hBC, 8'h10, 8'h00, 1'b1);
		reg_write(8'hB8, 8'h10, 8'h00, 1'b0);
		sel = 1'b0;
		oef = 1'b1;
		wr(8'h0B, 8'h00);
		cmp1(oe_o, 1'b1);
		wr(8'h0B, 8'h10);
		cmp1(oe_o, 1'b0);
		// signed limits -32..16 on both keyers, chroma -16 in two's complement
		wr(8'h0C, 8'hE0);
		wr(8'h0D, 8'h10);
		wr(8'h0E, 8'hE0);
		wr(8'h0F, 8'h10);
		chroma = 8'hF0;
		wr(8'h0B, 8'h20);
		cmp1(key, 1'b1);
		wr(8'h0B, 8'h00);
		cmp1(key, 1'b0);
		chroma = 8'h70;
		ticks(8);
		cmp1(key, 1'b1);
		wr(8'h0D, 8'hDF);
		cmp1(key, 1'b0);
		// qualifier idle level for both polarities
		for (int q = 0; q < 2; q++) begin
			wr(8'h10, {1'b0, q[0], q[0], 5'h00});
			free_run = 1'b1;
			ticks(40);
			free_run = 1'b0;
			cmp1(line_qualifier, !q[0]);
			cmp1(pixel_qualifier, !q[0]);
		end
		// transparent path keeps old word until the pipeline has run through
		wr(8'h10, 8'h10);
		free_run = 1'b1;
		luma = 8'h3C;
		chroma = 8'hA5;
		ticks(160);
		cmp32(word, {15'h0000, 1'b0, 8'h3C, 8'hA5});
		luma = 8'hC3;
		chroma = 8'h5A;
		line_reference = 1'b1;
		ticks(40);
		cmp32(word, {15'h0000, 1'b0, 8'h3C, 8'hA5});
		ticks(120);
		cmp32(word, {15'h0000, 1'b1, 8'hC3, 8'h5A});
		free_run = 1'b0;
		wr(8'h10, 8'h00);
		// line end raises request, prompt then slow controller
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			line_reference = 1'b1;
			// long enough for the controller to finish its previous burst
			ticks(60);
			line_reference = 1'b0;
			wait_flag(1'b1);
			wait_flag(1'b0);
		end
		close_out();
	end
	// hang guard
	initial begin
		#400000;
		fail_count++;
		close_out();
	end
endmodule : video_scaler_vertical_output_control_tb_top

// File: dv/vsvoc_properties.sv
`timescale 1ns/1ps
// port timing checks for the scaler control block
module vsvoc_properties (
	// clocks and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic vram_port_clock_i,
	// watched ports
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic line_reference_i,
	input wire logic port_output_enable_i,
	input wire logic [31:0] video_ram_output_port_o,
	input wire logic line_qualifier_o,
	input wire logic pixel_qualifier_o,
	input wire logic transfer_request_flag_o,
	input wire logic address_increment_strobe_o
);
	// everything is sampled on the line clock, fast enough to see each port edge
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// 810 ns and 840 ns expressed in 5 ns line clocks
	sequence clear_en_s;
		##[0:162] !transfer_request_flag_o;
	endsequence
	sequence clear_burst_s;
		##[0:168] !transfer_request_flag_o;
	endsequence
	sequence line_end_s;
		$fell(line_reference_i) && !transfer_request_flag_o;
	endsequence
	request_clear_a: assert property ($rose(port_output_enable_i) && transfer_request_flag_o |-> clear_en_s)
		else $error("request flag not cleared after enable");
	burst_clear_a: assert property (transfer_request_flag_o && port_output_enable_i |-> clear_burst_s)
		else $error("request flag not cleared during burst");
	flag_rise_a: assert property (line_end_s |-> ##[1:3] transfer_request_flag_o)
		else $error("request flag did not rise after line end");
	strobe_pulse_a: assert property (address_increment_strobe_o |=> !address_increment_strobe_o)
		else $error("increment strobe longer than one cycle");
	ack_scl_low_a: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("acknowledge started while bus clock high");
	ack_low_a: assert property (sda_oe_o |-> !sda_o)
		else $error("acknowledge drives data high");
	port_stable_a: assert property ($stable(vram_port_clock_i) |-> $stable(video_ram_output_port_o))
		else $error("port word changed without port clock edge");
	qual_stable_a: assert property ($stable(vram_port_clock_i) |-> $stable({line_qualifier_o, pixel_qualifier_o}))
		else $error("qualifier changed without port clock edge");
endmodule : vsvoc_properties

bind vsvoc_top vsvoc_properties u_props (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.vram_port_clock_i(vram_port_clock_i),
	.scl_i(scl_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.line_reference_i(line_reference_i),
	.port_output_enable_i(port_output_enable_i),
	.video_ram_output_port_o(video_ram_output_port_o),
	.line_qualifier_o(line_qualifier_o),
	.pixel_qualifier_o(pixel_qualifier_o),
	.transfer_request_flag_o(transfer_request_flag_o),
	.address_increment_strobe_o(address_increment_strobe_o)
);

// File: dv/vsvoc_vram_ctrl.sv
`timescale 1ns/1ps
// video ram controller model: answers requests with a clocked burst
module vsvoc_vram_ctrl (
	// bench control
	input wire logic rst_i,
	input wire logic free_run_i,
	input wire logic slow_i,
	// port side
	input wire logic transfer_request_flag_i,
	input wire logic [31:0] word_i,
	output logic vram_port_clock_o = 1'b0,
	output logic port_output_enable_o = 1'b0,
	output logic [31:0] word_o = 32'h0
);
	logic burst = 1'b0;
	int n;
	// port clock runs in reset, free run and bursts, else stands still; odd offset keeps it off the line clock
	initial begin
		#1.3;
		forever begin
			#15;
			vram_port_clock_o = (rst_i || free_run_i || burst) ? ~vram_port_clock_o : 1'b0;
		end
	end
	always @(posedge vram_port_clock_o) word_o <= word_i;
	// burst until the request drops, bounded so a stuck flag cannot hang it
	always @(posedge transfer_request_flag_i) begin
		#(slow_i ? 300 : 40);
		burst = 1'b1;
		port_output_enable_o = 1'b1;
		n = 0;
		while (transfer_request_flag_i && n < 40) begin
			@(posedge vram_port_clock_o);
			n++;
		end
		repeat (2) @(posedge vram_port_clock_o);
		port_output_enable_o = 1'b0;
		// a few more edges so the port side sees the release before the clock stops
		repeat (3) @(posedge vram_port_clock_o);
		burst = 1'b0;
	end
endmodule : vsvoc_vram_ctrl

// File: rtl/vsvoc_pkg.sv
package vsvoc_pkg;
	// register offsets on the serial control bus
	localparam logic [7:0] OFF_INPUT_LINES_LOW = 8'h06;
	localparam logic [7:0] OFF_WIN_START_LOW = 8'h07;
	localparam logic [7:0] OFF_VFILT_HIGH = 8'h08;
	localparam logic [7:0] OFF_BYP_START_LOW = 8'h09;
	localparam logic [7:0] OFF_BYP_COUNT_LOW = 8'h0A;
	localparam logic [7:0] OFF_BYP_HIGH_FMT = 8'h0B;
	localparam logic [7:0] OFF_KEY_V_LOWER = 8'h0C;
	localparam logic [7:0] OFF_KEY_V_UPPER = 8'h0D;
	localparam logic [7:0] OFF_KEY_U_LOWER = 8'h0E;
	localparam logic [7:0] OFF_KEY_U_UPPER = 8'h0F;
	localparam logic [7:0] OFF_OUT_CTRL = 8'h10;
	// field positions in register 0x08
	localparam int POS_AFS = 7;
	localparam int POS_VP = 5;
	localparam int POS_WS8 = 4;
	localparam int POS_ILC = 2;
	// field positions in register 0x0B
	localparam int POS_BS8 = 7;
	localparam int POS_BC8 = 6;
	localparam int POS_TCC = 5;
	localparam int POS_POE = 4;
	// field positions in register 0x10
	localparam int POS_MCT = 7;
	localparam int POS_QPP = 6;
	localparam int POS_QPL = 5;
	localparam int POS_TTR = 4;
	localparam int POS_EFE = 3;
	// serial bus write addresses
	localparam logic [7:0] ADDR_SEL_LOW = 8'hB8;
	localparam logic [7:0] ADDR_SEL_HIGH = 8'hBC;
	// reset value of every register
	localparam logic [7:0] REG_RESET = 8'h00;
	// window reference offset: value zero is third line after sync rise
	localparam int LINE_REF_OFFSET = 3;
	// transparent pipeline length in line-locked clocks
	localparam int TRANSP_DELAY = 58;
	// transfer request response limits
	localparam int HFL_EN_NS = 810;
	localparam int HFL_BURST_NS = 840;
	localparam int VRAM_PORT_CLOCK_NS = 30;
	localparam int HFL_EN_CYC = HFL_EN_NS / VRAM_PORT_CLOCK_NS;
	localparam int HFL_BURST_CYC = HFL_BURST_NS / VRAM_PORT_CLOCK_NS;
	// vertical processing codes
	localparam logic [1:0] VP_BYPASS = 2'h0;
	localparam logic [1:0] VP_DELAY = 2'h1;
	localparam logic [1:0] VP_AVG2 = 2'h2;
	localparam logic [1:0] VP_FILT3 = 2'h3;
	// serial slave states
	typedef enum logic [4:0] {
		SS_IDLE = 5'b00001,
		SS_ADDR = 5'b00010,
		SS_SUB = 5'b00100,
		SS_DATA = 5'b01000,
		SS_ACK = 5'b10000
	} vsvoc_ser_type;
endpackage : vsvoc_pkg

// File: rtl/vsvoc_top.sv
`timescale 1ns/1ps
// Function
// - ten-bit input line count per field, 0 to 1023, usable up to lines minus 3.
// - nine-bit window start; zero is third line after field sync rise.
// - adaptive switch off uses programmed filter codes; on lets scaler pick.
// - vertical code: bypass, one-line delay, two-line average, 1-2-1 over four.
// - bypass start line from same reference; scaling region wins on overlap.
// - nine-bit bypass line count sets bypass region length.
// - chroma input straight binary when zero, two's complement when one.
// - odd/even flag passed when polarity zero, inverted when one.
// - V keyer limits are signed eight-bit values.
// - U keyer limits are signed eight-bit values.
// - output representation select picks luma inversion or chroma coding.
// - line qualifier active low at zero, active high at one.
// - pixel qualifier active low at zero, active high at one.
// - transparent mode runs output as shift register, else burst protocol.
// - extended format enable puts one pixel in each word, else two pixels are packed.
// - transparent path delays luma, chroma, line reference by 58 clocks.
// - output port words update on rising port clock edges.
// - request flag rises on line clock, cleared by port clock in transfers.
// - request flag answers within 810 ns of enable, 840 ns of burst.
// - V keying disabled when V upper limit below V lower limit.
// - serial bus address B8h with select low, BCh with select high.
module vsvoc_top #(
	parameter int LINE_W = 512
) (
	// line-locked clock domain
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// serial control bus (open drain data)
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic address_select_pin_i,
	// video input
	input wire logic [7:0] luma_input_i,
	input wire logic [7:0] chroma_input_i,
	input wire logic line_reference_i,
	input wire logic field_sync_i,
	input wire logic odd_even_flag_i,
	input wire logic [1:0] output_format_select_i,
	// video ram port
	input wire logic vram_port_clock_i,
	input wire logic port_output_enable_i,
	output logic [31:0] video_ram_output_port_o,
	output logic line_qualifier_o,
	output logic pixel_qualifier_o,
	output logic transfer_request_flag_o,
	output logic address_increment_strobe_o,
	output logic odd_even_o,
	output logic key_o
);
	// elaboration check: the pixel counter and line memories need a sane width
	if (LINE_W < 4 || LINE_W > 1024) begin : g_line_w_check
		$error("LINE_W out of range");
	end

	// input synchronisers
	logic [2:0] scl_s_q, sda_s_q;
	logic [1:0] asel_s_q, vs_s_q, oe_s_q;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			asel_s_q <= 2'h0;
			vs_s_q <= 2'h0;
			oe_s_q <= 2'h0;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			asel_s_q <= {asel_s_q[0], address_select_pin_i};
			vs_s_q <= {vs_s_q[0], field_sync_i};
			oe_s_q <= {oe_s_q[0], odd_even_flag_i};
		end
	end
	wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
	wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
	wire bus_start = scl_s_q[1] & ~sda_s_q[1] & sda_s_q[2];
	wire bus_stop = scl_s_q[1] & sda_s_q[1] & ~sda_s_q[2];

	// serial slave: write-only, auto-incrementing subaddress
	vsvoc_pkg::vsvoc_ser_type ss_q;
	logic [7:0] sh_q, sub_q;
	logic [3:0] bit_q;
	logic ack_sub_q, ack_addr_q, wr_q;
	logic [7:0] regs_q [6:16];
	logic [7:0] my_addr;
	assign my_addr = asel_s_q[1] ? vsvoc_pkg::ADDR_SEL_HIGH : vsvoc_pkg::ADDR_SEL_LOW;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ss_q <= vsvoc_pkg::SS_IDLE;
			sh_q <= 8'h00;
			sub_q <= 8'h00;
			bit_q <= 4'h0;
			ack_sub_q <= 1'b0;
			ack_addr_q <= 1'b0;
			wr_q <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			if (bus_stop) begin
				ss_q <= vsvoc_pkg::SS_IDLE;
				sda_oe_o <= 1'b0;
			end else if (bus_start) begin
				ss_q <= vsvoc_pkg::SS_ADDR;
				bit_q <= 4'h0;
				sda_oe_o <= 1'b0;
			end else begin
				case (ss_q)
					vsvoc_pkg::SS_ADDR, vsvoc_pkg::SS_SUB, vsvoc_pkg::SS_DATA: begin
						if (scl_rise) begin
							sh_q <= {sh_q[6:0], sda_s_q[1]};
							bit_q <= bit_q + 4'h1;
						end
						if (scl_fall && bit_q == 4'h8) begin
							bit_q <= 4'h0;
							ack_sub_q <= (ss_q == vsvoc_pkg::SS_SUB);
							ack_addr_q <= (ss_q == vsvoc_pkg::SS_ADDR);
							if (ss_q == vsvoc_pkg::SS_ADDR && sh_q != my_addr) begin
								ss_q <= vsvoc_pkg::SS_IDLE;
							end else begin
								if (ss_q == vsvoc_pkg::SS_SUB) begin
									sub_q <= sh_q;
								end
								if (ss_q == vsvoc_pkg::SS_DATA) begin
									wr_q <= 1'b1;
								end
								sda_o <= 1'b0;
								sda_oe_o <= 1'b1;
								ss_q <= vsvoc_pkg::SS_ACK;
							end
						end
					end
					vsvoc_pkg::SS_ACK: begin
						if (scl_fall) begin
							sda_oe_o <= 1'b0;
							// the byte just acked decides what follows, not a stale subaddress
							if (ack_addr_q) begin
								ss_q <= vsvoc_pkg::SS_SUB;
							end else begin
								ss_q <= vsvoc_pkg::SS_DATA;
							end
							// subaddress steps on after each data byte
							if (!ack_addr_q && !ack_sub_q) begin
								sub_q <= sub_q + 8'h01;
							end
						end
					end
					default: ss_q <= vsvoc_pkg::SS_IDLE;
				endcase
			end
		end
	end

	// register file write; unmapped subaddresses are ignored
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			for (int i = 6; i <= 16; i++) begin
				regs_q[i] <= vsvoc_pkg::REG_RESET;
			end
		end else if (wr_q && sub_q >= vsvoc_pkg::OFF_INPUT_LINES_LOW && sub_q <= vsvoc_pkg::OFF_OUT_CTRL) begin
			regs_q[sub_q[4:0]] <= sh_q;
		end
	end

	// field decode of the live registers
	logic [7:0] r8, rb, r10;
	assign r8 = regs_q[8];
	assign rb = regs_q[11];
	assign r10 = regs_q[16];

	// field start detection
	logic vs_d_q;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			vs_d_q <= 1'b0;
		end else begin
			vs_d_q <= vs_s_q[1];
		end
	end
	wire field_start = vs_s_q[1] & ~vs_d_q;

	// shadow fields loaded at field start
	logic [9:0] in_lines_q;
	logic [8:0] win_start_q, byp_start_q, byp_count_q;
	logic afs_q;
	logic [1:0] vp_q;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			in_lines_q <= 10'h000;
			win_start_q <= 9'h000;
			byp_start_q <= 9'h000;
			byp_count_q <= 9'h000;
			afs_q <= 1'b0;
			vp_q <= vsvoc_pkg::VP_BYPASS;
		end else if (field_start) begin
			in_lines_q <= {r8[vsvoc_pkg::POS_ILC+1 -: 2], regs_q[6]};
			win_start_q <= {r8[vsvoc_pkg::POS_WS8], regs_q[7]};
			byp_start_q <= {rb[vsvoc_pkg::POS_BS8], regs_q[9]};
			byp_count_q <= {rb[vsvoc_pkg::POS_BC8], regs_q[10]};
			afs_q <= r8[vsvoc_pkg::POS_AFS];
			vp_q <= r8[vsvoc_pkg::POS_VP+1 -: 2];
		end
	end

	// line counter from field start; count 3, window line 0, is third line after sync rise
	logic [10:0] line_q;
	logic line_reference_d_q;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			line_q <= 11'h000;
			line_reference_d_q <= 1'b0;
		end else begin
			line_reference_d_q <= line_reference_i;
			if (field_start) begin
				line_q <= 11'h000;
			end else if (line_reference_i && !line_reference_d_q) begin
				line_q <= line_q + 11'h001;
			end
		end
	end
	logic [10:0] rel_line;
	assign rel_line = line_q - 11'(vsvoc_pkg::LINE_REF_OFFSET);
	function automatic logic in_range(input logic [10:0] l, input logic [8:0] s, input logic [10:0] n);
		in_range = (l >= {2'b00, s}) && (l < {2'b00, s} + n);
	endfunction
	logic in_win, in_byp;
	assign in_win = (line_q >= 11'(vsvoc_pkg::LINE_REF_OFFSET)) && in_range(rel_line, win_start_q, {1'b0, in_lines_q});
	assign in_byp = !in_win && (line_q >= 11'(vsvoc_pkg::LINE_REF_OFFSET))
		&& in_range(rel_line, byp_start_q, {2'b00, byp_count_q});

	// line memories for vertical filtering
	logic [7:0] lm1 [LINE_W];
	logic [7:0] lm2 [LINE_W];
	logic [$clog2(LINE_W)-1:0] px_q;
	logic [7:0] p1_q, p2_q, luma_q, chroma_q;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			px_q <= '0;
		end else if (!line_reference_i) begin
			px_q <= '0;
		end else begin
			px_q <= px_q + 1'b1;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		lm1[px_q] <= luma_input_i;
		lm2[px_q] <= lm1[px_q];
		p1_q <= lm1[px_q];
		p2_q <= lm2[px_q];
		luma_q <= luma_input_i;
	end
	// chroma input converted to two's complement internally
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			chroma_q <= 8'h00;
		end else begin
			chroma_q <= rb[vsvoc_pkg::POS_TCC] ? chroma_input_i : (chroma_input_i ^ 8'h80);
		end
	end
	// adaptive switch picks three-line filter itself
	logic [1:0] vp_eff;
	assign vp_eff = afs_q ? vsvoc_pkg::VP_FILT3 : vp_q;
	logic [9:0] vsum;
	logic [7:0] vout_q;
	always_comb begin
		case (vp_eff)
			vsvoc_pkg::VP_DELAY: vsum = {p1_q, 2'b00};
			vsvoc_pkg::VP_AVG2: vsum = {({1'b0, luma_q} + {1'b0, p1_q}), 1'b0};
			vsvoc_pkg::VP_FILT3: vsum = {2'b00, luma_q} + {1'b0, p1_q, 1'b0} + {2'b00, p2_q};
			default: vsum = {luma_q, 2'b00};
		endcase
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			vout_q <= 8'h00;
		end else begin
			vout_q <= (in_win && !in_byp) ? vsum[9:2] : luma_q;
		end
	end

	logic key_q;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			key_q <= 1'b0;
		end else begin
			key_q <= ($signed(regs_q[13]) >= $signed(regs_q[12]))
				&& $signed(chroma_q) >= $signed(regs_q[12]) && $signed(chroma_q) <= $signed(regs_q[13])
				&& $signed(chroma_q) >= $signed(regs_q[14]) && $signed(chroma_q) <= $signed(regs_q[15]);
		end
	end

	// transparent delay line, one stage short of the full delay; the word register makes the last
	logic [16:0] tp_q [vsvoc_pkg::TRANSP_DELAY-1];
	always_ff @(posedge ref_clk_i) begin
		tp_q[0] <= {line_reference_i, luma_input_i, chroma_input_i};
		for (int i = 1; i < vsvoc_pkg::TRANSP_DELAY - 1; i++) begin
			tp_q[i] <= tp_q[i-1];
		end
	end

	logic efe, output_representation_select;
	assign efe = r10[vsvoc_pkg::POS_EFE];
	assign output_representation_select = r10[vsvoc_pkg::POS_MCT];
	logic [7:0] y_out, uv_out;
	assign y_out = (output_format_select_i == 2'h3 && !output_representation_select) ? ~vout_q : vout_q;
	assign uv_out = output_representation_select ? chroma_q : (chroma_q ^ 8'h80);
	logic [31:0] word_q;
	logic word_tgl_q, line_q2;
	// a word loads only after the port side took the last one; with no fifo a
	// stream faster than the port clock is thinned out instead of torn
	logic [2:0] w_s_q;
	logic [1:0] wack_s_q;
	logic word_rdy;
	assign word_rdy = (wack_s_q[1] == word_tgl_q);
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			word_q <= 32'h0000_0000;
			word_tgl_q <= 1'b0;
			wack_s_q <= 2'h0;
			line_q2 <= 1'b0;
			address_increment_strobe_o <= 1'b0;
		end else begin
			line_q2 <= line_reference_d_q;
			wack_s_q <= {wack_s_q[0], w_s_q[2]};
			address_increment_strobe_o <= 1'b0;
			// transparent word passes whenever the port side is ready
			if (word_rdy && r10[vsvoc_pkg::POS_TTR]) begin
				word_q <= {15'h0000, tp_q[vsvoc_pkg::TRANSP_DELAY-2]};
				word_tgl_q <= ~word_tgl_q;
			end else if (word_rdy && line_reference_d_q && (in_win || in_byp)) begin
				word_q <= efe ? {16'h0000, y_out, uv_out} : {word_q[15:0], y_out, uv_out};
				word_tgl_q <= ~word_tgl_q;
			end
			// increment strobe timed from line clock at line end
			if (!line_reference_d_q && line_q2) begin
				address_increment_strobe_o <= 1'b1;
			end
		end
	end

	// request flag rises on line clock
	logic req_set_tgl_q, req_clr_s1_q, req_clr_s2_q, req_pend_q;
	logic ack_tgl_q;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			req_set_tgl_q <= 1'b0;
			req_clr_s1_q <= 1'b0;
			req_clr_s2_q <= 1'b0;
			req_pend_q <= 1'b0;
			transfer_request_flag_o <= 1'b0;
		end else begin
			req_clr_s1_q <= ack_tgl_q;
			req_clr_s2_q <= req_clr_s1_q;
			if (!line_reference_d_q && line_q2 && !r10[vsvoc_pkg::POS_TTR]) begin
				req_set_tgl_q <= ~req_set_tgl_q;
				req_pend_q <= 1'b1;
				transfer_request_flag_o <= 1'b1;
			end else if (req_clr_s2_q == req_set_tgl_q && req_pend_q) begin
				req_pend_q <= 1'b0;
				transfer_request_flag_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			odd_even_o <= 1'b0;
			key_o <= 1'b0;
		end else begin
			odd_even_o <= oe_s_q[1] ^ rb[vsvoc_pkg::POS_POE];
			key_o <= key_q;
		end
	end

	// port clock domain: word handed over by toggle, stable for two edges
	logic [1:0] pe_s_q, lq_s_q;
	logic act_q;
	logic [1:0] r_s_q;
	logic [4:0] burst_q;
	always_ff @(posedge vram_port_clock_i) begin
		if (rst_i) begin
			w_s_q <= 3'h0;
			r_s_q <= 2'h0;
			pe_s_q <= 2'h0;
			lq_s_q <= 2'h0;
			ack_tgl_q <= 1'b0;
			act_q <= 1'b0;
			burst_q <= 5'h00;
			video_ram_output_port_o <= 32'h0000_0000;
			line_qualifier_o <= 1'b0;
			pixel_qualifier_o <= 1'b0;
		end else begin
			w_s_q <= {w_s_q[1:0], word_tgl_q};
			r_s_q <= {r_s_q[0], req_set_tgl_q};
			pe_s_q <= {pe_s_q[0], port_output_enable_i};
			lq_s_q <= {lq_s_q[0], line_q2};
			// data updated on port clock rising edge
			if (w_s_q[2] != w_s_q[1]) begin
				video_ram_output_port_o <= word_q;
			end
			line_qualifier_o <= ~(lq_s_q[1] ^ r10[vsvoc_pkg::POS_QPL]);
			pixel_qualifier_o <= ~((w_s_q[2] != w_s_q[1]) ^ r10[vsvoc_pkg::POS_QPP]);
			// flag cleared from port clock within bound
			act_q <= pe_s_q[1] && (r_s_q[1] != ack_tgl_q);
			// stop counting at once after the ack so no stray count carries over
			if (act_q && r_s_q[1] != ack_tgl_q) begin
				burst_q <= burst_q + 5'h01;
				if (burst_q == 5'(vsvoc_pkg::HFL_BURST_CYC / 4)) begin
					ack_tgl_q <= r_s_q[1];
					burst_q <= 5'h00;
				end
			end
		end
	end
endmodule : vsvoc_top
